// ===== inc/rdt_pkg.sv
// Purpose: shared constants and field layouts of the reload down-counter timer
// Assumes: 32-bit APB data, one aligned word per register
// Notes: narrow registers sit in the low bits, upper bits read as zero
package rdt_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_IOCTL = 8'h04;
    localparam logic [7:0] OFF_MODE = 8'h08;
    localparam logic [7:0] OFF_COUNT = 8'h0C;
    localparam logic [7:0] OFF_EVSRC = 8'h10;
    localparam logic [7:0] OFF_ROUTE = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
    localparam logic [7:0] OFF_CLK_EN = 8'h20;

    // control register bit positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_STATUS = 1;
    localparam int CTRL_FSTOP = 2;
    localparam int CTRL_EDGE = 4;
    localparam int CTRL_UNDER = 5;

    // interrupt status / mask bit positions
    localparam int IRQ_UNDER = 0;
    localparam int IRQ_EDGE = 1;

    // reset values
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [15:0] RST_REG16 = 16'h0000;

    // operating modes
    localparam logic [2:0] MODE_TIMER = 3'h0;
    localparam logic [2:0] MODE_PULSE = 3'h1;
    localparam logic [2:0] MODE_EVENT = 3'h2;
    localparam logic [2:0] MODE_WIDTH = 3'h3;
    localparam logic [2:0] MODE_PERIOD = 3'h4;

    // count sources
    localparam logic [2:0] SRC_CLK = 3'h0;
    localparam logic [2:0] SRC_CLK_DIV2 = 3'h1;
    localparam logic [2:0] SRC_CLK_DIV8 = 3'h2;
    localparam logic [2:0] SRC_LOW_OSC = 3'h3;
    localparam logic [2:0] SRC_SUB = 3'h4;
    localparam logic [2:0] SRC_EVENT_LINK = 3'h5;

    // event source field codes
    localparam logic [2:0] EVS_PIN = 3'h0;
    localparam logic [2:0] EVS_IRQ_IN = 3'h1;
    localparam logic [2:0] EVS_IRQ_IN_INV = 3'h2;
    localparam logic [2:0] EVS_PEER = 3'h3;
    localparam logic [2:0] EVS_PEER_INV = 3'h4;

    // start/stop latency: cpu cycles when fast, count-source ticks when slow
    localparam logic [1:0] LAT_FAST = 2'h2;
    localparam logic [1:0] LAT_SLOW = 2'h3;

    // filter sample counter match values (periods of 8 and 32 cpu cycles) and agreeing samples
    localparam logic [4:0] FILT_DIV_MID = 5'h07;
    localparam logic [4:0] FILT_DIV_SLOW = 5'h1F;
    localparam int FILT_TAPS = 3;

    typedef struct packed {
        logic event_gate_hi;
        logic event_gate_lo;
        logic filter_select_hi;
        logic filter_select_lo;
        logic rsv3;
        logic output_enable_bit;
        logic rsv1;
        logic input_polarity_select;
    } io_ctrl_t;

    typedef struct packed {
        logic rsv7;
        logic [2:0] count_source;
        logic edge_count_polarity;
        logic [2:0] op_mode_field;
    } mode_t;

endpackage : rdt_pkg

// ===== rtl/count_tick_gen.sv
// Purpose: one-cycle count-source tick from the selected source
// Assumes: oscillator and link inputs are synchronous to clock
// Notes: slow clocks are counted on their rising edge
`timescale 1ns/100ps
module count_tick_gen (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic [2:0] source,
    input wire logic low_speed_osc_clock,
    input wire logic sub_clock,
    input wire logic event_link_unit,
    output logic tick
);
    import rdt_pkg::*;

    logic [2:0] div_r;
    logic low_prev_r;
    logic sub_prev_r;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_r <= 3'h0;
            low_prev_r <= 1'b0;
            sub_prev_r <= 1'b0;
        end else if (clear) begin
            div_r <= 3'h0;
            low_prev_r <= 1'b0;
            sub_prev_r <= 1'b0;
        end else begin
            div_r <= div_r + 3'h1;
            low_prev_r <= low_speed_osc_clock;
            sub_prev_r <= sub_clock;
        end
    end

    always_comb begin
        case (source)
            SRC_CLK: tick = 1'b1;
            SRC_CLK_DIV2: tick = div_r[0];
            SRC_CLK_DIV8: tick = (div_r == 3'h7);
            SRC_LOW_OSC: tick = low_speed_osc_clock & ~low_prev_r;
            SRC_SUB: tick = sub_clock & ~sub_prev_r;
            SRC_EVENT_LINK: tick = event_link_unit;
            default: tick = 1'b0;
        endcase
    end
endmodule : count_tick_gen

// ===== rtl/input_filter.sv
// Purpose: digital noise filter for the event input pin
// Assumes: select 0 bypasses the filter with one register stage
// Notes: output moves only when all taps agree, costing settle time
`timescale 1ns/100ps
module input_filter #(
    parameter int TAPS = 3
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic raw,
    input wire logic [1:0] select,
    output logic filtered
);
    import rdt_pkg::*;

    logic [4:0] div_r;
    logic [TAPS-1:0] taps_r;
    logic sample;

    always_comb begin
        case (select)
            2'h1: sample = 1'b1;
            2'h2: sample = (div_r[2:0] == FILT_DIV_MID[2:0]);
            2'h3: sample = (div_r == FILT_DIV_SLOW);
            default: sample = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_r <= 5'h00;
            taps_r <= '0;
            filtered <= 1'b0;
        end else if (clear) begin
            div_r <= 5'h00;
            taps_r <= '0;
            filtered <= 1'b0;
        end else begin
            div_r <= div_r + 5'h01;
            if (sample) begin
                taps_r <= {taps_r[TAPS-2:0], raw};
            end
            if (select == 2'h0) begin
                filtered <= raw;
            end else if (&taps_r) begin
                filtered <= 1'b1;
            end else if (~|taps_r) begin
                filtered <= 1'b0;
            end
        end
    end
endmodule : input_filter

// ===== rtl/reload_timer.sv
// Purpose: 16-bit reload down-counter timer with APB registers
// Assumes: zero-wait APB slave, all pins synchronous to clock
// Notes: clock-supply enable low acts as a synchronous soft reset
//
// What this block does
// R1: start shows idle for 2 cycles (fast) or 3 count-source ticks (slow)
// R2: stop shows counting for 2 cycles (fast) or 3 count-source ticks (slow)
// R3: forced stop is write-only, reads zero
// R4: software waits 5 filter clocks before start
// R5: polarity change under filter needs 5 clocks
// R6: unused timer: timer mode, output disabled
// R7: low-speed source needs oscillator select first
// R8: no low-speed source while subclock drives others
// R9: mode source bits 6-4, mode bits 2-0
// R10: mode bit 3 picks single or both edges
// R11: one plain 16-bit down counter, no prescaler
// R12: event source select acts in event mode only
// R13: four-bit pin routing register
// R14: control bits underflow5 edge4 stop2 status1 run0
// R15: counter write hits reload, read gives count, or the captured count in period mode
// R16: clock enable low holds reset, blocks writes
// R17: decrement per tick, underflow after zero
// R18: underflow reloads counter, sets sticky flag
`timescale 1ns/100ps
module reload_timer #(
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic event_io_pin,
    input wire logic external_irq_input,
    input wire logic peer_timer_signal,
    input wire logic event_link_unit,
    input wire logic low_speed_osc_clock,
    input wire logic sub_clock,
    output logic toggle_output_pin,
    output logic toggle_output_en,
    output logic [3:0] pin_routing_sel,
    output logic underflow_event,
    output logic irq
);
    import rdt_pkg::*;

    logic clk_en_r;
    io_ctrl_t io_r;
    mode_t mode_r;
    logic [15:0] reload_r, count_r, capture_r;
    logic [2:0] evsrc_r;
    logic [3:0] route_r;
    logic [1:0] irq_stat_r, irq_mask_r;
    logic run_r, status_r, under_flag_r, edge_flag_r;
    logic [1:0] lat_cnt_r;
    logic toggle_r, lvl_prev_r, ev_prev_r;
    logic [31:0] rd_nxt;
    logic mapped, wr, rd_setup, wr_ctrl, force_stop;
    logic tick, filt, fast, lat_step, lat_done, start_now;
    logic lvl, act_rise, act_fall, ev_sig, gate_ok, ev_step;
    logic step, capture_now, underflow;
    logic [1:0] lat_last;

    // apb decode
    assign wr = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_comb begin
        mapped = 1'b1;
        rd_nxt = 32'h0000_0000;
        case (paddr)
            ADDR_W'(OFF_CTRL): rd_nxt[7:0] = {2'b00, under_flag_r, edge_flag_r, 2'b00, status_r, run_r}; // [R14] [R3]
            ADDR_W'(OFF_IOCTL): rd_nxt[7:0] = io_r;
            ADDR_W'(OFF_MODE): rd_nxt[7:0] = mode_r;
            ADDR_W'(OFF_COUNT): rd_nxt[15:0] = (mode_r.op_mode_field == MODE_PERIOD) ? capture_r : count_r; // [R15]
            ADDR_W'(OFF_EVSRC): rd_nxt[2:0] = evsrc_r;
            ADDR_W'(OFF_ROUTE): rd_nxt[3:0] = route_r;
            ADDR_W'(OFF_IRQ_STAT): rd_nxt[1:0] = irq_stat_r;
            ADDR_W'(OFF_IRQ_MASK): rd_nxt[1:0] = irq_mask_r;
            ADDR_W'(OFF_CLK_EN): rd_nxt[0] = clk_en_r;
            default: mapped = 1'b0;
        endcase
        // registers other than clock enable read as zero while clock supply is off
        if (!clk_en_r && paddr != ADDR_W'(OFF_CLK_EN)) begin // [R16]
            rd_nxt = 32'h0000_0000;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup && !pwrite) begin
            prdata <= rd_nxt;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            clk_en_r <= 1'b0;
        end else if (wr && paddr == ADDR_W'(OFF_CLK_EN)) begin
            clk_en_r <= pwdata[0];
        end
    end

    assign wr_ctrl = wr & clk_en_r & (paddr == ADDR_W'(OFF_CTRL));
    assign force_stop = wr_ctrl & pwdata[CTRL_FSTOP]; // [R3]

    // configuration registers, held at reset values while clock supply is off
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            io_r <= io_ctrl_t'(RST_REG8);
            mode_r <= mode_t'(RST_REG8);
            reload_r <= RST_REG16;
            evsrc_r <= RST_REG8[2:0];
            route_r <= RST_REG8[3:0];
            irq_mask_r <= RST_REG8[1:0];
        end else if (!clk_en_r) begin // [R16]
            io_r <= io_ctrl_t'(RST_REG8);
            mode_r <= mode_t'(RST_REG8);
            reload_r <= RST_REG16;
            evsrc_r <= RST_REG8[2:0];
            route_r <= RST_REG8[3:0];
            irq_mask_r <= RST_REG8[1:0];
        end else if (wr) begin
            case (paddr)
                ADDR_W'(OFF_IOCTL): io_r <= io_ctrl_t'({pwdata[7:4], 1'b0, pwdata[2], 1'b0, pwdata[0]});
                ADDR_W'(OFF_MODE): mode_r <= mode_t'({1'b0, pwdata[6:0]}); // [R9] [R10]
                ADDR_W'(OFF_COUNT): reload_r <= pwdata[15:0]; // [R15]
                ADDR_W'(OFF_EVSRC): evsrc_r <= pwdata[2:0];
                ADDR_W'(OFF_ROUTE): route_r <= pwdata[3:0]; // [R13]
                ADDR_W'(OFF_IRQ_MASK): irq_mask_r <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    count_tick_gen u_tick (
        .clock(clock),
        .reset_n(reset_n),
        .clear(!clk_en_r),
        .source(mode_r.count_source),
        .low_speed_osc_clock(low_speed_osc_clock),
        .sub_clock(sub_clock),
        .event_link_unit(event_link_unit),
        .tick(tick)
    );

    input_filter #(
        .TAPS(FILT_TAPS)
    ) u_filt (
        .clock(clock),
        .reset_n(reset_n),
        .clear(!clk_en_r),
        .raw(event_io_pin),
        .select({io_r.filter_select_hi, io_r.filter_select_lo}),
        .filtered(filt)
    );

    // run bit and delayed counting status
    assign fast = (mode_r.op_mode_field == MODE_EVENT) || (mode_r.count_source == SRC_EVENT_LINK);
    assign lat_last = fast ? (LAT_FAST - 2'h1) : (LAT_SLOW - 2'h1);
    assign lat_step = fast ? 1'b1 : tick;
    assign lat_done = (run_r != status_r) && lat_step && (lat_cnt_r == lat_last);
    assign start_now = lat_done && run_r && !force_stop;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            run_r <= 1'b0;
            status_r <= 1'b0;
            lat_cnt_r <= 2'h0;
        end else if (!clk_en_r || force_stop) begin // [R3] [R16]
            run_r <= 1'b0;
            status_r <= 1'b0;
            lat_cnt_r <= 2'h0;
        end else begin
            if (wr_ctrl) begin
                run_r <= pwdata[CTRL_RUN];
            end
            if (run_r == status_r) begin
                lat_cnt_r <= 2'h0;
            end else if (lat_done) begin // [R1] [R2]
                status_r <= run_r;
                lat_cnt_r <= 2'h0;
            end else if (lat_step) begin
                lat_cnt_r <= lat_cnt_r + 2'h1;
            end
        end
    end

    // input conditioning: measurement uses the filtered pin
    assign lvl = filt ^ io_r.input_polarity_select;
    assign act_rise = lvl & ~lvl_prev_r;
    assign act_fall = ~lvl & lvl_prev_r;

    always_comb begin
        ev_sig = lvl;
        if (mode_r.op_mode_field == MODE_EVENT) begin // [R12]
            case (evsrc_r)
                EVS_IRQ_IN: ev_sig = external_irq_input;
                EVS_IRQ_IN_INV: ev_sig = ~external_irq_input;
                EVS_PEER: ev_sig = peer_timer_signal;
                EVS_PEER_INV: ev_sig = ~peer_timer_signal;
                default: ev_sig = lvl;
            endcase
        end
        case ({io_r.event_gate_hi, io_r.event_gate_lo})
            2'h1: gate_ok = external_irq_input;
            2'h2: gate_ok = ~external_irq_input;
            2'h3: gate_ok = peer_timer_signal;
            default: gate_ok = 1'b1;
        endcase
    end

    // both edges counted when the edge polarity bit is set
    assign ev_step = gate_ok & (mode_r.edge_count_polarity ? (ev_sig ^ ev_prev_r) : (ev_sig & ~ev_prev_r)); // [R10]

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lvl_prev_r <= 1'b0;
            ev_prev_r <= 1'b0;
        end else begin
            lvl_prev_r <= lvl;
            ev_prev_r <= ev_sig;
        end
    end

    always_comb begin
        capture_now = 1'b0;
        case (mode_r.op_mode_field)
            MODE_EVENT: step = ev_step;
            MODE_WIDTH: step = tick & lvl;
            MODE_PERIOD: begin
                step = tick;
                capture_now = act_rise;
            end
            default: step = tick;
        endcase
    end

    assign underflow = status_r && step && !capture_now && count_r == 16'h0000; // [R17]
    assign underflow_event = underflow;

    // single down counter, reloaded on start, underflow or capture
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= RST_REG16;
            capture_r <= RST_REG16;
        end else if (!clk_en_r) begin
            count_r <= RST_REG16;
            capture_r <= RST_REG16;
        end else if (start_now) begin
            count_r <= reload_r;
        end else if (status_r) begin
            if (capture_now) begin
                capture_r <= count_r;
                count_r <= reload_r;
            end else if (underflow) begin // [R18]
                count_r <= reload_r;
            end else if (step) begin // [R11] [R17]
                count_r <= count_r - 16'h0001;
            end
        end
    end

    // sticky flags: hardware set beats a software clear in the same cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            under_flag_r <= 1'b0;
            edge_flag_r <= 1'b0;
            irq_stat_r <= 2'b00;
        end else if (!clk_en_r) begin
            under_flag_r <= 1'b0;
            edge_flag_r <= 1'b0;
            irq_stat_r <= 2'b00;
        end else begin
            if (underflow) begin // [R18]
                under_flag_r <= 1'b1;
            end else if (wr_ctrl && !pwdata[CTRL_UNDER]) begin
                under_flag_r <= 1'b0;
            end
            if (status_r && (capture_now || (mode_r.op_mode_field == MODE_WIDTH && act_fall))) begin
                edge_flag_r <= 1'b1;
            end else if (wr_ctrl && !pwdata[CTRL_EDGE]) begin
                edge_flag_r <= 1'b0;
            end
            for (int i = 0; i < 2; i++) begin
                if (wr && paddr == ADDR_W'(OFF_IRQ_STAT) && pwdata[i]) begin
                    irq_stat_r[i] <= 1'b0;
                end
            end
            if (underflow) begin // [R17]
                irq_stat_r[IRQ_UNDER] <= 1'b1;
            end
            if (status_r && (capture_now || (mode_r.op_mode_field == MODE_WIDTH && act_fall))) begin
                irq_stat_r[IRQ_EDGE] <= 1'b1;
            end
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // toggle output inverts on underflow in pulse output mode
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            toggle_r <= 1'b0;
        end else if (!clk_en_r || !io_r.output_enable_bit) begin
            toggle_r <= 1'b0;
        end else if (underflow && mode_r.op_mode_field == MODE_PULSE) begin
            toggle_r <= ~toggle_r;
        end
    end

    assign toggle_output_pin = toggle_r;
    assign toggle_output_en = io_r.output_enable_bit;
    assign pin_routing_sel = route_r; // [R13]

    property p_start_fast;
        @(posedge clock) disable iff (!reset_n)
        $rose(run_r) && fast && clk_en_r && !status_r |-> (!status_r)[*2] ##1 (status_r || !run_r);
    endproperty
    a_start_fast: assert property (p_start_fast) else $error("fast start latency wrong"); // [R1]

    property p_stop_fast;
        @(posedge clock) disable iff (!reset_n)
        $fell(run_r) && fast && clk_en_r && status_r && !$past(force_stop) |-> status_r[*2] ##1 (!status_r || run_r);
    endproperty
    a_stop_fast: assert property (p_stop_fast) else $error("fast stop latency wrong"); // [R2]

    property p_start_slow;
        @(posedge clock) disable iff (!reset_n)
        start_now && !fast |-> lat_cnt_r == 2'h2 && tick;
    endproperty
    a_start_slow: assert property (p_start_slow) else $error("slow start not on third tick"); // [R1]

    property p_force_stop;
        @(posedge clock) disable iff (!reset_n)
        force_stop |=> !run_r && !status_r ##1 prdata[CTRL_FSTOP] == 1'b0;
    endproperty
    a_force_stop: assert property (p_force_stop) else $error("forced stop did not halt"); // [R3]

    property p_reload_write;
        @(posedge clock) disable iff (!reset_n)
        wr && clk_en_r && paddr == ADDR_W'(OFF_COUNT) && !status_r && !start_now
        |=> reload_r == $past(pwdata[15:0]) && count_r == $past(count_r);
    endproperty
    a_reload_write: assert property (p_reload_write) else $error("counter write leaked into count"); // [R15]

    property p_clk_off;
        @(posedge clock) disable iff (!reset_n)
        !clk_en_r |=> !run_r && count_r == 16'h0000 && mode_r == mode_t'(RST_REG8);
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("timer not held in reset"); // [R16]

    property p_decrement;
        @(posedge clock) disable iff (!reset_n)
        clk_en_r && status_r && step && !capture_now && count_r != 16'h0000 && !force_stop
        |=> count_r == $past(count_r) - 16'h0001;
    endproperty
    a_decrement: assert property (p_decrement) else $error("count did not decrement"); // [R17]

    property p_underflow;
        @(posedge clock) disable iff (!reset_n)
        clk_en_r && status_r && step && !capture_now && count_r == 16'h0000 && !force_stop
        |=> count_r == $past(reload_r) && under_flag_r && irq_stat_r[IRQ_UNDER];
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow reload or flag missing"); // [R18]

    property p_irq;
        @(posedge clock) disable iff (!reset_n)
        clk_en_r && underflow && irq_mask_r[IRQ_UNDER] && !(wr && paddr == ADDR_W'(OFF_IRQ_MASK)) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("unmasked underflow raised no interrupt"); // [R17]

    c_start: cover property (@(posedge clock) disable iff (!reset_n) start_now);
    c_underflow: cover property (@(posedge clock) disable iff (!reset_n) underflow ##1 irq);
    c_capture: cover property (@(posedge clock) disable iff (!reset_n) status_r && capture_now);
    c_stop: cover property (@(posedge clock) disable iff (!reset_n) $fell(status_r));
endmodule : reload_timer

// ===== dv/pulse_source.sv
// Purpose: event source driving the timer's event input pin
// Assumes: pulses are synchronous to clock
// Notes: pin idles low; each level is held long enough for the filter
`timescale 1ns/100ps
module pulse_source (
    input wire logic clock,
    output logic pin
);
    initial pin = 1'b0;
    task automatic burst(input int n);
        repeat (n) begin
            @(posedge clock);
            pin <= 1'b1;
            repeat (5) @(posedge clock);
            pin <= 1'b0;
            repeat (5) @(posedge clock);
        end
    endtask : burst
endmodule : pulse_source

// ===== dv/reload_down_counter_timer_tb.sv
// Purpose: register-level bench of the reload down-counter timer
// Assumes: zero-wait apb slave, one idle cycle between transfers
// Notes: slow start/stop checked with clk/8 so the window is wide
`timescale 1ns/100ps
module reload_down_counter_timer_tb;
    import rdt_pkg::*;
    logic clock, reset_n, psel, penable, pwrite, pready, pslverr, err, ev_pin;
    logic toggle_output_pin, toggle_output_en, underflow_event, irq, irq_in, peer_in;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pin_routing_sel;
    int errors, comparisons, n;
    reload_timer u_reload_timer (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_io_pin(ev_pin), .external_irq_input(irq_in), .peer_timer_signal(peer_in),
        .event_link_unit(1'b0), .low_speed_osc_clock(1'b0), .sub_clock(1'b0),
        .toggle_output_pin(toggle_output_pin), .toggle_output_en(toggle_output_en),
        .pin_routing_sel(pin_routing_sel), .underflow_event(underflow_event), .irq(irq));
    pulse_source u_pulse_source (.clock(clock), .pin(ev_pin));
    always #5 clock = ~clock;
    task automatic close_out();
        if (errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0000_0000);
        check(what, rd, exp);
    endtask : rchk
    // underflow event output is combinational, so it is sampled mid-cycle
    task automatic wait_uf();
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (underflow_event !== 1'b1 && n < 300);
        @(posedge clock);
    endtask : wait_uf
    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        close_out();
    end
    initial begin
        clock = 1'b0;
        reset_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, irq_in, peer_in} = '0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        wr(OFF_MODE, 32'h0000_0012);
        rchk("mode gated", OFF_MODE, 32'h0000_0000);
        wr(OFF_CLK_EN, 32'h0000_0001);
        rchk("mode kept reset", OFF_MODE, 32'h0000_0000);
        xfer(8'h24, 1'b0, 32'h0000_0000);
        check("unmapped err", err, 1);
        wr(OFF_MODE, 32'hFFFF_FF5A);
        rchk("mode fields", OFF_MODE, 32'h0000_005A);
        wr(OFF_ROUTE, 32'h0000_00FF);
        rchk("routing", OFF_ROUTE, 32'h0000_000F);
        check("routing pins", pin_routing_sel, 4'hF);
        wr(OFF_IOCTL, 32'h0000_0004);
        check("out en", toggle_output_en, 1);
        wr(OFF_IOCTL, 32'h0000_0000);
        check("out dis", toggle_output_en, 0);
        wr(OFF_COUNT, 32'h0000_0007);
        rchk("count unloaded", OFF_COUNT, 32'h0000_0000);
        wr(OFF_IOCTL, 32'h0000_0004);
        wr(OFF_MODE, {25'h0, 3'h2, 1'b0, MODE_PULSE}); // low-speed source never chosen
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        wr(OFF_CTRL, 32'h0000_0001);
        rchk("start idle", OFF_CTRL, 32'h0000_0001);
        wait_uf();
        wait_uf();
        check("uf period", n, 64);
        check("irq up", irq, 1);
        rchk("flags", OFF_CTRL, 32'h0000_0023);
        check("toggle even", toggle_output_pin, 0);
        wait_uf();
        rchk("irq stat", OFF_IRQ_STAT, 32'h0000_0001);
        check("toggle odd", toggle_output_pin, 1);
        wr(OFF_IRQ_MASK, 32'h0000_0000);
        check("irq masked", irq, 0);
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        wr(OFF_CTRL, 32'h0000_0001);
        wr(OFF_IRQ_STAT, 32'h0000_0001);
        check("irq cleared", irq, 0);
        xfer(OFF_COUNT, 1'b0, 32'h0000_0000);
        check("live count", rd <= 32'd7 && rd != 32'd0, 1);
        wr(OFF_CTRL, 32'h0000_0000);
        rchk("stop busy", OFF_CTRL, 32'h0000_0002);
        repeat (40) @(posedge clock);
        rchk("stopped", OFF_CTRL, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0001);
        wr(OFF_CTRL, 32'h0000_0005);
        rchk("forced stop", OFF_CTRL, 32'h0000_0000);
        wr(OFF_MODE, {29'h0, MODE_EVENT});
        wr(OFF_EVSRC, {29'h0, EVS_PIN});
        wr(OFF_COUNT, 32'h0000_0005);
        wr(OFF_IOCTL, 32'h0000_0010);
        repeat (5) @(posedge clock);
        wr(OFF_CTRL, 32'h0000_0001);
        repeat (4) @(posedge clock);
        rchk("fast start", OFF_CTRL, 32'h0000_0003);
        u_pulse_source.burst(3);
        rchk("single edge", OFF_COUNT, 32'h0000_0002);
        wr(OFF_CTRL, 32'h0000_0000);
        repeat (4) @(posedge clock);
        wr(OFF_MODE, {28'h0, 1'b1, MODE_EVENT});
        wr(OFF_CTRL, 32'h0000_0001);
        repeat (4) @(posedge clock);
        u_pulse_source.burst(2);
        rchk("both edges", OFF_COUNT, 32'h0000_0001);
        wr(OFF_EVSRC, {29'h0, EVS_IRQ_IN});
        u_pulse_source.burst(2);
        rchk("source moved", OFF_COUNT, 32'h0000_0001);
        irq_in <= 1'b1;
        @(posedge clock);
        irq_in <= 1'b0;
        @(posedge clock);
        rchk("irq source", OFF_COUNT, 32'h0000_0005);
        wr(OFF_EVSRC, {29'h0, EVS_PEER});
        peer_in <= 1'b1;
        @(posedge clock);
        peer_in <= 1'b0;
        @(posedge clock);
        rchk("peer source", OFF_COUNT, 32'h0000_0003);
        wr(OFF_CTRL, 32'h0000_0000);
        wr(OFF_MODE, {29'h0, MODE_PERIOD});
        wr(OFF_COUNT, 32'h0000_0100);
        wr(OFF_CTRL, 32'h0000_0001);
        u_pulse_source.burst(1);
        rchk("period edge", OFF_CTRL, 32'h0000_0013);
        wr(OFF_CLK_EN, 32'h0000_0000);
        rchk("held reset", OFF_CTRL, 32'h0000_0000);
        close_out();
    end
endmodule : reload_down_counter_timer_tb
